// File: dac_device.sv
// dual dac slave: two-wire receiver, double-buffered channel registers
// Functional notes
// RL1 - write: address w, pointer, two data, stop
// RL2 - ack matching address and pointer byte
// RL3 - pointer read: repeated start, address r
// RL4 - bare read uses last loaded pointer
// RL5 - pointer bit0 a, bit1 b
// RL6 - both selected: same data both channels
// RL7 - 16-bit word msb first, control bits
// RL8 - code left-justified below bit 12
// RL9 - clear zero wipes all registers; code clears the input and dac registers only, not pd_a, pd_b or the pointer
// RL10 - load zero updates both dac registers
// RL11 - load one updates input register only
// RL12 - input register changes only on completion
// RL13 - dac updates only if input rewritten
// RL14 - pointer resets zero, default readback
// RL15 - both selected read returns default
// RL16 - readback same layout, unused bits zero
// RL17 - acked second byte repeats word
// RL18 - power-down mode decode
// RL19 - power-down keeps dac registers
// RL20 - wake timed from eighth clock rise; code starts the count at the eighth clock fall of the second data byte
// RL21 - address 000110 plus select pin
// RL22 - reset clears registers, normal mode
// RL23 - per-channel power-down mode storage
// RL24 - ignore other slaves' traffic
module dac_device (
  input  wire logic             clk,
  input  wire logic             resetn,
  dac_link_if.device            link,
  input  wire logic             address_select_pin,
  output logic [11:0]           dac_code_a,
  output logic [11:0]           dac_code_b,
  output logic [1:0]            pd_mode_a,
  output logic [1:0]            pd_mode_b,
  output logic                  analog_on_a,
  output logic                  analog_on_b
);
  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_addr  = 3'h1,
    st_ptr   = 3'h2,
    st_data  = 3'h3,
    st_read  = 3'h4,
    st_ignore = 3'h5
  } state_e;

  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic [1:0]  asel_s;
    logic        scl_p;
    logic        sda_p;
    state_e      st;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        ack_phase;
    logic        sda_oe;
    logic [1:0]  ptr;
    logic [15:0] word;
    logic        byte_n;
    logic        word_done;
    logic [11:0] in_a;
    logic [11:0] in_b;
    logic [11:0] out_a;
    logic [11:0] out_b;
    logic        upd_a;
    logic        upd_b;
    logic [1:0]  pd_a;
    logic [1:0]  pd_b;
    logic [15:0] tx;
    logic        nacked;
    logic [9:0]  wake_a;
    logic [9:0]  wake_b;
  } state_s;

  localparam logic [9:0] wake_count = 10'(dac_pkg::wake_cycles);

  state_s q;
  state_s d;

  function automatic logic [15:0] readback(input logic [1:0] p,
                                           input state_s s);
    logic [15:0] r;
    r = dac_pkg::default_readback; // RL14 RL15
    if (p == 2'h1)
      r = {s.pd_a, 2'h2, s.in_a}; // RL16
    else if (p == 2'h2)
      r = {s.pd_b, 2'h2, s.in_b};
    return r;
  endfunction : readback

  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  assign scl     = q.scl_s[1];
  assign sda     = q.sda_s[1];
  assign rise    = scl & ~q.scl_p;
  assign fall    = ~scl & q.scl_p;
  assign start_c = scl & q.scl_p & q.sda_p & ~sda;
  assign stop_c  = scl & q.scl_p & ~q.sda_p & sda;

  always_comb
  begin
    d = q;
    d.scl_s = {q.scl_s[0], link.scl_i};
    d.sda_s = {q.sda_s[0], link.sda_i};
    d.asel_s = {q.asel_s[0], address_select_pin};
    d.scl_p = scl;
    d.sda_p = sda;
    if (q.wake_a != 10'h0)
      d.wake_a = q.wake_a - 10'h1;
    if (q.wake_b != 10'h0)
      d.wake_b = q.wake_b - 10'h1;
    if (start_c)
    begin
      d.st = st_addr;
      d.bitn = 4'h0;
      d.ack_phase = 1'b0;
      d.sda_oe = 1'b0;
      d.byte_n = 1'b0;
    end
    else if (stop_c)
    begin
      d.st = st_idle;
      d.sda_oe = 1'b0;
      if (q.word_done) // RL12
      begin
        d.word_done = 1'b0;
        if (!q.word[dac_pkg::word_clear_bit]) // RL9
        begin
          d.in_a = 12'h0;
          d.in_b = 12'h0;
          d.out_a = 12'h0;
          d.out_b = 12'h0;
          d.upd_a = 1'b0;
          d.upd_b = 1'b0;
        end
        else
        begin
          if (q.ptr[dac_pkg::ptr_sel_a_bit]) // RL6 RL8
          begin
            d.in_a = q.word[11:0];
            d.upd_a = 1'b1;
          end
          if (q.ptr[dac_pkg::ptr_sel_b_bit])
          begin
            d.in_b = q.word[11:0];
            d.upd_b = 1'b1;
          end
          if (!q.word[dac_pkg::word_load_bit]) // RL10 RL11
          begin
            if (d.upd_a) // RL13
              d.out_a = d.in_a;
            if (d.upd_b)
              d.out_b = d.in_b;
            d.upd_a = 1'b0;
            d.upd_b = 1'b0;
          end
        end
      end
    end
    else if (q.st != st_idle && rise && !q.ack_phase)
    begin
      d.shreg = {q.shreg[6:0], sda}; // RL7
      d.bitn = q.bitn + 4'h1;
    end
    else if (q.st != st_idle && rise && q.ack_phase && q.st == st_read)
      d.nacked = sda; // RL17
    else if (q.st != st_idle && fall)
    begin
      if (!q.ack_phase && q.bitn == 4'h8)
      begin
        d.ack_phase = 1'b1;
        d.bitn = 4'h0;
        d.sda_oe = 1'b0;
        case (q.st)
          st_addr:
          begin
            if (q.shreg[7:1] ==
                {dac_pkg::addr_upper, q.asel_s[1]}) // RL21
            begin
              d.sda_oe = 1'b1; // RL2
              if (q.shreg[0]) // RL3 RL4
              begin
                d.st = st_read;
                d.tx = readback(q.ptr, q);
                // high byte goes out first after this ack
                d.byte_n = 1'b1;
              end
              else
                d.st = st_ptr;
            end
            else
              d.st = st_ignore; // RL24
          end
          st_ptr:
          begin
            d.sda_oe = 1'b1; // RL2
            d.ptr = q.shreg[1:0]; // RL5
            d.word_done = 1'b0;
            d.st = st_data;
          end
          st_data:
          begin
            d.sda_oe = 1'b1;
            if (!q.byte_n)
              d.word[15:8] = q.shreg;
            else
            begin
              d.word[7:0] = q.shreg;
              d.word_done = 1'b1; // RL1
              if (q.ptr[dac_pkg::ptr_sel_a_bit]) // RL23 RL18
                d.pd_a = q.word[15:14];
              if (q.ptr[dac_pkg::ptr_sel_b_bit])
                d.pd_b = q.word[15:14];
              if (q.word[15:14] == dac_pkg::pd_normal) // RL20
              begin
                if (q.ptr[0] && q.pd_a != dac_pkg::pd_normal)
                  d.wake_a = wake_count;
                if (q.ptr[1] && q.pd_b != dac_pkg::pd_normal)
                  d.wake_b = wake_count;
              end
            end
            d.byte_n = ~q.byte_n;
          end
          default: d.sda_oe = 1'b0;
        endcase
      end
      else if (q.ack_phase)
      begin
        d.ack_phase = 1'b0;
        d.sda_oe = 1'b0;
        if (q.st == st_read)
        begin
          if (q.nacked)
            d.st = st_ignore;
          else
          begin
            d.byte_n = ~q.byte_n;
            d.sda_oe = ~(q.byte_n ? q.tx[15] : q.tx[7]); // RL17
          end
        end
      end
      else if (q.st == st_read)
      begin
        d.sda_oe = ~(q.byte_n ? q.tx[7 - q.bitn[2:0]]
                              : q.tx[15 - q.bitn[2:0]]);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0; // RL22 RL14
    else
      q <= d;
  end

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = q.sda_oe;
  assign dac_code_a    = q.out_a; // RL19
  assign dac_code_b    = q.out_b;
  assign pd_mode_a     = q.pd_a;
  assign pd_mode_b     = q.pd_b;
  assign analog_on_a   = (q.pd_a == dac_pkg::pd_normal) && q.wake_a == 10'h0;
  assign analog_on_b   = (q.pd_b == dac_pkg::pd_normal) && q.wake_b == 10'h0;
endmodule : dac_device

// File: dac_pkg.sv
// shared constants for the dual dac two-wire slave and its master
package dac_pkg;
  // =====================================================
  // address and pointer layout
  localparam logic [5:0] addr_upper      = 6'h06;
  localparam int         ptr_sel_a_bit   = 0;
  localparam int         ptr_sel_b_bit   = 1;
  // =====================================================
  // data word layout
  localparam int         word_pd_hi      = 15;
  localparam int         word_pd_lo      = 14;
  localparam int         word_clear_bit  = 13;
  localparam int         word_load_bit   = 12;
  localparam int         code_width      = 12;
  localparam logic [15:0] default_readback = 16'h2000;
  // =====================================================
  // power-down modes
  localparam logic [1:0] pd_normal       = 2'h0;
  localparam logic [1:0] pd_1k           = 2'h1;
  localparam logic [1:0] pd_100k         = 2'h2;
  localparam logic [1:0] pd_tristate     = 2'h3;
  // =====================================================
  // timing
  localparam int         clk_mhz         = 250;
  localparam int         wake_ns         = 2500;
  localparam int         wake_cycles     = wake_ns * clk_mhz / 1000;
  localparam int         scl_half_cycles = 8;
endpackage : dac_pkg

// File: dac_link_if.sv
// two-wire link between the bus master and the dual dac
interface dac_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  scl_i = scl_oe ? scl_o : 1'b1;
  wire  sda_i = (sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o) ? 1'b0 : 1'b1;
  modport device (input scl_i, input sda_i, output sda_s_o, output sda_s_oe);
  modport master (input scl_i, input sda_i, output scl_o, output scl_oe,
                  output sda_m_o, output sda_m_oe);
endinterface : dac_link_if

// File: dac_master.sv
// two-wire master issuing dac writes and reads from a simple command port
module dac_master (
  input  wire logic        clk,
  input  wire logic        resetn,
  dac_link_if.master       link,
  input  wire logic        go,
  input  wire logic        rd,
  input  wire logic        use_ptr,
  input  wire logic        addr_lsb,
  input  wire logic [7:0]  ptr_byte,
  input  wire logic [15:0] wr_word,
  output logic             busy,
  output logic             done,
  output logic             nack_seen,
  output logic [15:0]      rd_word
);
  typedef enum logic [2:0] {
    m_idle  = 3'h0,
    m_start = 3'h1,
    m_byte  = 3'h2,
    m_stop  = 3'h3,
    m_fin   = 3'h4
  } mstate_e;

  typedef struct packed {
    mstate_e     st;
    logic [3:0]  div;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [2:0]  idx;
    logic [2:0]  nbytes;
    logic [5:0][7:0] bytes;
    logic        rstart;
    logic        scl;
    logic        sda;
    logic        rd;
    logic [15:0] rx;
    logic        nack;
    logic        done;
    logic [1:0]  sda_s;
  } mstate_s;

  localparam logic [3:0] half = 4'(dac_pkg::scl_half_cycles - 1);

  mstate_s q;
  mstate_s d;
  logic    tick;
  logic    is_rd_byte;

  assign tick       = q.div == 4'h0;
  assign is_rd_byte = q.rd && (q.idx >= q.nbytes - 3'h2);

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.sda_s = {q.sda_s[0], link.sda_i};
    d.div = tick ? half : q.div - 4'h1;
    case (q.st)
      m_idle:
      begin
        d.scl = 1'b1;
        d.sda = 1'b1;
        if (go)
        begin
          d.rd = rd;
          d.nack = 1'b0;
          d.idx = 3'h0;
          d.bitn = 4'h0;
          d.ph = 2'h0;
          d.st = m_start;
          d.bytes[0] = {dac_pkg::addr_upper, addr_lsb, 1'b0}; // RL1
          d.bytes[1] = ptr_byte; // RL5
          d.rstart = rd && use_ptr; // RL3
          if (!rd)
          begin
            d.bytes[2] = wr_word[15:8];
            d.bytes[3] = wr_word[7:0];
            d.nbytes = 3'h4;
          end
          else if (use_ptr)
          begin
            d.bytes[2] = {dac_pkg::addr_upper, addr_lsb, 1'b1};
            d.nbytes = 3'h5;
          end
          else
          begin
            d.bytes[0] = {dac_pkg::addr_upper, addr_lsb, 1'b1};
            d.nbytes = 3'h3;
          end
        end
      end
      m_start:
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h0)
          begin
            d.scl = 1'b1;
            d.sda = 1'b1;
          end
          else if (q.ph == 2'h1)
            d.sda = 1'b0;
          else
          begin
            d.scl = 1'b0;
            d.ph = 2'h0;
            d.st = m_byte;
          end
        end
      m_byte:
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h0)
          begin
            if (q.bitn < 4'h8)
              d.sda = is_rd_byte ? 1'b1 : q.bytes[q.idx][7 - q.bitn[2:0]];
            else
              d.sda = !is_rd_byte || (q.idx == q.nbytes - 3'h1); // RL17
          end
          else if (q.ph == 2'h1)
          begin
            d.scl = 1'b1;
            if (q.bitn < 4'h8 && is_rd_byte)
              d.rx = {q.rx[14:0], q.sda_s[1]};
            if (q.bitn == 4'h8 && !is_rd_byte && q.sda_s[1])
              d.nack = 1'b1;
          end
          else
          begin
            d.scl = 1'b0;
            d.ph = 2'h0;
            d.bitn = q.bitn + 4'h1;
            if (q.bitn == 4'h8)
            begin
              d.bitn = 4'h0;
              d.idx = q.idx + 3'h1;
              if (q.idx == q.nbytes - 3'h1 || d.nack)
                d.st = m_stop;
              else if (q.rstart && q.idx == 3'h1)
                d.st = m_start;
            end
          end
        end
      m_stop:
        if (tick)
        begin
          d.ph = q.ph + 2'h1;
          if (q.ph == 2'h0)
            d.sda = 1'b0;
          else if (q.ph == 2'h1)
            d.scl = 1'b1;
          else
          begin
            d.sda = 1'b1;
            d.st = m_fin;
          end
        end
      m_fin:
      begin
        d.done = 1'b1;
        d.st = m_idle;
      end
      default: d.st = m_idle;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = (q.st != m_idle) && !q.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = (q.st != m_idle) && !q.sda;
  assign busy          = q.st != m_idle;
  assign done          = q.done;
  assign nack_seen     = q.nack;
  assign rd_word       = q.rx;
endmodule : dac_master

// File: dac_link_monitor.sv
// concurrent checks on the two-wire link between master and dual dac
module dac_link_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  wire dev_low = sda_s_oe & ~sda_s_o;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // =====================================================
  // bus conditions
  sequence start_s;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence stop_s;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  // =====================================================
  // assertions
  scl_open_drain_a: assert property (scl_oe |-> !scl_o)
    else $error("scl driven high");
  scl_high_min_a: assert property ($rose(scl_i) |-> scl_i [*8])
    else $error("scl high phase too short");
  // no stretching on this link, so a low phase is bounded
  scl_low_max_a: assert property ($fell(scl_i) |-> ##[1:40] scl_i)
    else $error("scl held low too long");
  dev_drive_low_a: assert property ($rose(dev_low) |-> !scl_i)
    else $error("device took sda while scl high");
  dev_release_a: assert property ($fell(dev_low) |-> !scl_i)
    else $error("device let sda go while scl high");
  dev_hold_high_a: assert property (
    scl_i && $past(scl_i) |-> $stable(dev_low))
    else $error("device sda changed while scl high");
  start_quiet_a: assert property (start_s |-> !dev_low [*8])
    else $error("device drove sda right after start");
  stop_quiet_a: assert property (stop_s |-> !dev_low [*8])
    else $error("device drove sda after stop");
  // =====================================================
  // cover
  start_c: cover property (start_s);
  stop_c: cover property (stop_s);
  ack_c: cover property ($rose(dev_low));
  mst_c: cover property (sda_m_oe && !sda_m_o);
endmodule : dac_link_monitor

// File: dual_dac_serial_register_logic_tb.sv
// bench: master and dual dac back to back, checked through the command port, the dac code and power-down outputs, and analog_on_a
module dual_dac_serial_register_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        go = 1'b0;
  logic        rd = 1'b0;
  logic        use_ptr = 1'b0;
  logic        addr_lsb = 1'b0;
  logic        address_select_pin = 1'b0;
  logic [7:0]  ptr_byte = 8'h00;
  logic [15:0] wr_word = 16'h0000;
  logic        busy, done, nack_seen, analog_on_a, analog_on_b;
  logic [15:0] rd_word;
  logic [11:0] dac_code_a, dac_code_b;
  logic [1:0]  pd_mode_a, pd_mode_b;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  dac_link_if link ();
  dac_device dac_device_inst (.clk(clk), .resetn(resetn), .link(link),
    .address_select_pin(address_select_pin), .dac_code_a(dac_code_a),
    .dac_code_b(dac_code_b), .pd_mode_a(pd_mode_a), .pd_mode_b(pd_mode_b),
    .analog_on_a(analog_on_a), .analog_on_b(analog_on_b));
  dac_master dac_master_inst (.clk(clk), .resetn(resetn), .link(link),
    .go(go), .rd(rd), .use_ptr(use_ptr), .addr_lsb(addr_lsb),
    .ptr_byte(ptr_byte), .wr_word(wr_word), .busy(busy), .done(done),
    .nack_seen(nack_seen), .rd_word(rd_word));
  dac_link_monitor dac_link_monitor_inst (.clk(clk), .resetn(resetn),
    .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
    .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe), .scl_i(link.scl_i), .sda_i(link.sda_i));
  always #2 clk = ~clk;
  // =====================================================
  // tasks
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one command, then time for the device registers to settle
  task automatic xfer(input logic r, p, input logic [7:0] pb,
                      input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    rd <= r;
    use_ptr <= p;
    ptr_byte <= pb;
    wr_word <= w;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
      err_total++;
    repeat (8) @(negedge clk);
  endtask : xfer
  task automatic codes(input logic [11:0] a, b);
    chk("code_a", {4'h0, dac_code_a}, {4'h0, a});
    chk("code_b", {4'h0, dac_code_b}, {4'h0, b});
  endtask : codes
  // =====================================================
  // watchdog, far above the roughly 15000 cycles of the run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      final_report();
    end
  end
  // =====================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    codes(12'h000, 12'h000);
    chk("pd_a", {14'h0, pd_mode_a}, 16'h0);
    xfer(1'b1, 1'b0, 8'h00, 16'h0);
    chk("bare_rd", rd_word, dac_pkg::default_readback);
    xfer(1'b0, 1'b1, 8'h01, 16'h3abc);
    codes(12'h000, 12'h000);
    chk("ack_ptr", {15'h0, nack_seen}, 16'h0);
    xfer(1'b1, 1'b1, 8'h01, 16'h0);
    chk("rb_code", {4'h0, rd_word[11:0]}, 16'h0abc);
    xfer(1'b1, 1'b0, 8'h00, 16'h0);
    chk("rb_keep", {4'h0, rd_word[11:0]}, 16'h0abc);
    xfer(1'b0, 1'b1, 8'h02, 16'h2123);
    codes(12'habc, 12'h123);
    xfer(1'b0, 1'b1, 8'h02, 16'h2456);
    codes(12'habc, 12'h456);
    xfer(1'b1, 1'b1, 8'h02, 16'h0);
    chk("rb_b", {4'h0, rd_word[11:0]}, 16'h0456);
    xfer(1'b0, 1'b1, 8'h03, 16'h6999);
    codes(12'h999, 12'h999);
    chk("pd_b", {14'h0, pd_mode_b}, 16'h1);
    chk("on_a", {15'h0, analog_on_a}, 16'h0);
    xfer(1'b1, 1'b1, 8'h03, 16'h0);
    chk("rb_both", rd_word, dac_pkg::default_readback);
    for (int m = 3; m >= 0; m--)
    begin
      xfer(1'b0, 1'b1, 8'h01, {m[1:0], 2'b10, 12'h0f0});
      chk("pd_a", {14'h0, pd_mode_a}, {14'h0, m[1:0]});
      chk("pd_b", {14'h0, pd_mode_b}, 16'h1);
    end
    chk("wake_a", {15'h0, analog_on_a}, 16'h0);
    // wake time is 625 cycles; leave margin
    repeat (700) @(negedge clk);
    chk("on_a", {15'h0, analog_on_a}, 16'h1);
    xfer(1'b0, 1'b1, 8'h01, 16'h1fff);
    codes(12'h000, 12'h000);
    @(posedge clk);
    addr_lsb <= 1'b1;
    xfer(1'b0, 1'b1, 8'h01, 16'h2111);
    chk("nack", {15'h0, nack_seen}, 16'h1);
    codes(12'h000, 12'h000);
    @(posedge clk);
    address_select_pin <= 1'b1;
    xfer(1'b0, 1'b1, 8'h01, 16'h2222);
    chk("nack", {15'h0, nack_seen}, 16'h0);
    codes(12'h222, 12'h000);
    final_report();
  end
endmodule : dual_dac_serial_register_logic_tb
